// *** inc/lios_map.svh ***
// Constants for the linkage I/O sequencer: bit positions and timing.
`ifndef LIOS_MAP_SVH
`define LIOS_MAP_SVH

// ----------------------------------------------------------------------
// Command input vector layout
// ----------------------------------------------------------------------
`define LIOS_NUM_IN      8
`define LIOS_BIT_START   0
`define LIOS_BIT_STOP    1
`define LIOS_BIT_PAUSE   2
`define LIOS_BIT_HOME    3
`define LIOS_BIT_PWR_ON  4
`define LIOS_BIT_SHUT    5
`define LIOS_BIT_WCLR    6
`define LIOS_BIT_TEACH   7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LIOS_CLK_NS      10
`define LIOS_ALIVE_WAIT_S 10
`define LIOS_ALIVE_WAIT_CYC (`LIOS_ALIVE_WAIT_S * (1000000000 / `LIOS_CLK_NS))
`define LIOS_PRESS_MS    100
`define LIOS_PRESS_CYC   (`LIOS_PRESS_MS * 1000000 / `LIOS_CLK_NS)

`endif

// *** inc/lios_pkg.sv ***
// Types shared by both ends of the linkage I/O sequencer.
package lios_pkg;

  // --------------------------------------------------------------------
  // Program sequencing states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    LIOS_IDLE  = 2'b00,
    LIOS_RUN   = 2'b01,
    LIOS_PAUSE = 2'b10
  } lios_state_e;

  typedef logic [7:0] lios_cmd_t;

  // Rising edge of each bit between two samples
  function automatic lios_cmd_t lios_rise(input lios_cmd_t cur,
                                          input lios_cmd_t prev);
    return cur & ~prev;
  endfunction : lios_rise

endpackage : lios_pkg

// *** inc/lios_if.sv ***
// Linkage I/O lines between the external controller and the robot box.
`timescale 1ns/100ps
`default_nettype none

interface lios_if;
  // Controller to robot box
  logic prog_start_in;
  logic prog_stop_in;
  logic prog_pause_in;
  logic return_home_in;
  logic remote_power_on_in;
  logic remote_shutdown_in;
  logic warning_clear_in;
  logic force_teach_in;
  // Robot box to controller
  logic running_out;
  logic stopped_out;
  logic paused_out;
  logic at_home_out;
  logic software_alive_out;

  modport dev (
    input  prog_start_in, prog_stop_in, prog_pause_in, return_home_in,
           remote_power_on_in, remote_shutdown_in, warning_clear_in,
           force_teach_in,
    output running_out, stopped_out, paused_out, at_home_out,
           software_alive_out
  );

  modport host (
    output prog_start_in, prog_stop_in, prog_pause_in, return_home_in,
           remote_power_on_in, remote_shutdown_in, warning_clear_in,
           force_teach_in,
    input  running_out, stopped_out, paused_out, at_home_out,
           software_alive_out
  );
endinterface : lios_if

`default_nettype wire

// *** hw/lios_device.sv ***
// Robot box end of the linkage I/O sequencer.
// Function
// (R1) Start/stop/pause/home act only in linkage mode
// (R2) Manual mode ignores linkage command inputs; power-on, shutdown and warning-clear still act in manual mode
// (R3) Start: run, drop stopped and at-home
// (R4) Pause presses alternate pause and resume
// (R5) Stop halts motion, asserts stopped
// (R6) Home moves only while held; at-home on arrival
// (R7) Remote power-on accepted in every mode
// (R8) Remote shutdown accepted in every mode
// (R9) Stopped asserted from box power-up
// (R10) Software-alive once control software booted
// (R11) Controller waits 10 s after software-alive
// (R12) Warning-clear clears pending warnings
// (R13) Collision pauses; clear then pause resumes
// (R14) Hand teaching enabled while force-teach held
// (R15) Pause and teach latching; home held as a level; others momentary
// (R16) Inputs synchronised; edges act, home/teach levels
`timescale 1ns/100ps
`default_nettype none
`include "lios_map.svh"

module lios_device
  import lios_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  lios_if.dev       link,
  input  wire logic linkage_mode,
  input  wire logic collision,
  input  wire logic home_reached,
  input  wire logic boot_done,
  output var  logic system_power,
  output var  logic motion_run,
  output var  logic motion_home,
  output var  logic teach_enable,
  output var  logic warning_pending,
  output var  logic warning_clear_pulse
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  lios_cmd_t cmd_raw;
  lios_cmd_t cmd_meta;
  lios_cmd_t cmd_sync;
  lios_cmd_t cmd_prev;
  lios_cmd_t cmd_rise;
  logic      pause_edge;
  logic      cmd_ok;
  logic      home_req;

  // Gather the pins into one vector
  always_comb begin
    cmd_raw                   = '0;
    cmd_raw[`LIOS_BIT_START]  = link.prog_start_in;
    cmd_raw[`LIOS_BIT_STOP]   = link.prog_stop_in;
    cmd_raw[`LIOS_BIT_PAUSE]  = link.prog_pause_in;
    cmd_raw[`LIOS_BIT_HOME]   = link.return_home_in;
    cmd_raw[`LIOS_BIT_PWR_ON] = link.remote_power_on_in;
    cmd_raw[`LIOS_BIT_SHUT]   = link.remote_shutdown_in;
    cmd_raw[`LIOS_BIT_WCLR]   = link.warning_clear_in;
    cmd_raw[`LIOS_BIT_TEACH]  = link.force_teach_in;
  end

  // Two stages; the first stage feeds nothing but the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_meta <= '0;
      cmd_sync <= '0;
      cmd_prev <= '0;
    end else begin
      cmd_meta <= cmd_raw;             // see (R16)
      cmd_sync <= cmd_meta;
      cmd_prev <= cmd_sync;
    end
  end

  // Edge decode; pause comes from a latching switch so both edges count
  assign cmd_rise   = lios_rise(cmd_sync, cmd_prev);  // see (R16)
  assign pause_edge = cmd_sync[`LIOS_BIT_PAUSE] ^
                      cmd_prev[`LIOS_BIT_PAUSE];      // see (R15)

  // Program commands need linkage mode and a powered system
  assign cmd_ok = linkage_mode && system_power;       // see (R1) (R2)

  // --------------------------------------------------------------------
  // Power sequencing
  // --------------------------------------------------------------------
  // Power and shutdown ignore the mode switch; shutdown wins a tie
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      system_power <= 1'b0;
    end else if (cmd_rise[`LIOS_BIT_SHUT]) begin
      system_power <= 1'b0;                           // see (R8)
    end else if (cmd_rise[`LIOS_BIT_PWR_ON]) begin
      system_power <= 1'b1;                           // see (R7)
    end
  end

  // Alive follows the boot flag but only while powered
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link.software_alive_out <= 1'b0;
    end else begin
      link.software_alive_out <= system_power && boot_done; // see (R10)
    end
  end

  // --------------------------------------------------------------------
  // Program state machine
  // --------------------------------------------------------------------
  lios_state_e state;
  lios_state_e next_state;

  // Stop beats pause when edges collide in one cycle; idle decodes start only
  always_comb begin
    next_state = state;
    if (!system_power) begin
      next_state = LIOS_IDLE;
    end else if (collision && state == LIOS_RUN) begin
      next_state = LIOS_PAUSE;                        // see (R13)
    end else if (cmd_ok) begin
      unique case (state)
        LIOS_IDLE: begin
          if (cmd_rise[`LIOS_BIT_START]) begin
            next_state = LIOS_RUN;                    // see (R3)
          end
        end
        LIOS_RUN: begin
          if (cmd_rise[`LIOS_BIT_STOP]) begin
            next_state = LIOS_IDLE;                   // see (R5)
          end else if (pause_edge) begin
            next_state = LIOS_PAUSE;                  // see (R4)
          end
        end
        LIOS_PAUSE: begin
          if (cmd_rise[`LIOS_BIT_STOP]) begin
            next_state = LIOS_IDLE;                   // see (R5)
          end else if (pause_edge && !warning_pending) begin
            next_state = LIOS_RUN;                    // see (R4) (R13)
          end
        end
        default: next_state = LIOS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= LIOS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // Warnings
  // --------------------------------------------------------------------
  // A collision in the clearing cycle keeps the warning alive
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      warning_pending     <= 1'b0;
      warning_clear_pulse <= 1'b0;
    end else begin
      warning_clear_pulse <= cmd_rise[`LIOS_BIT_WCLR];  // see (R12)
      if (collision) begin
        warning_pending <= 1'b1;
      end else if (cmd_rise[`LIOS_BIT_WCLR]) begin
        warning_pending <= 1'b0;                        // see (R12)
      end
    end
  end

  // --------------------------------------------------------------------
  // Return home and teaching
  // --------------------------------------------------------------------
  // Homing runs from a stopped program while the level is held and no
  // warning blocks motion; releasing the input halts it on the third clock edge
  assign home_req = cmd_ok && state == LIOS_IDLE &&
                    cmd_sync[`LIOS_BIT_HOME] && !warning_pending;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      motion_home <= 1'b0;
    end else begin
      motion_home <= home_req && !home_reached &&
                     !link.at_home_out;                 // see (R6)
    end
  end

  // Arrival latches at-home; any program start clears it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link.at_home_out <= 1'b0;
    end else if (!system_power || next_state == LIOS_RUN) begin
      link.at_home_out <= 1'b0;                         // see (R3)
    end else if (motion_home && home_reached) begin
      link.at_home_out <= 1'b1;                         // see (R6)
    end
  end

  // Teaching follows the held level, gated by the mode switch
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      teach_enable <= 1'b0;
    end else begin
      teach_enable <= cmd_ok && cmd_sync[`LIOS_BIT_TEACH]; // see (R14)
    end
  end

  // --------------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------------
  // Stopped shows from reset on, so the controller sees it at power-up
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link.running_out <= 1'b0;
      link.stopped_out <= 1'b1;                         // see (R9)
      link.paused_out  <= 1'b0;
      motion_run       <= 1'b0;
    end else begin
      link.running_out <= next_state == LIOS_RUN;       // see (R3) (R4)
      link.stopped_out <= next_state == LIOS_IDLE;      // see (R5) (R9)
      link.paused_out  <= next_state == LIOS_PAUSE;     // see (R4) (R13)
      motion_run       <= next_state == LIOS_RUN;
    end
  end

endmodule : lios_device

`default_nettype wire

// *** hw/lios_host.sv ***
// External controller end of the linkage I/O sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "lios_map.svh"

module lios_host
  import lios_pkg::*;
#(
  parameter int unsigned ALIVE_WAIT_CYC = `LIOS_ALIVE_WAIT_CYC,
  parameter int unsigned PRESS_CYC      = `LIOS_PRESS_CYC
)
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  lios_if.host      link,
  input  wire logic req_start,
  input  wire logic req_stop,
  input  wire logic req_pause,
  input  wire logic req_power_on,
  input  wire logic req_shutdown,
  input  wire logic req_warn_clear,
  input  wire logic req_teach,
  input  wire logic hold_home,
  output logic      cmd_ready,
  output var  logic running,
  output var  logic stopped,
  output var  logic paused,
  output var  logic at_home,
  output var  logic alive_settled
);

  // --------------------------------------------------------------------
  // Settling wait after the robot reports alive
  // --------------------------------------------------------------------
  logic [31:0] wait_cnt;
  logic [31:0] press_cnt;
  logic [5:0]  press_bits;
  logic        alive_prev;
  logic        any_req;

  // Restart the wait on every rising alive; drop readiness when lost
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alive_prev    <= 1'b0;
      wait_cnt      <= '0;
      alive_settled <= 1'b0;
    end else begin
      alive_prev <= link.software_alive_out;
      if (!link.software_alive_out) begin
        alive_settled <= 1'b0;
        wait_cnt      <= '0;
      end else if (!alive_prev) begin
        wait_cnt <= ALIVE_WAIT_CYC;                   // see (R11)
      end else if (wait_cnt != '0) begin
        wait_cnt <= wait_cnt - 32'h1;
      end else begin
        alive_settled <= 1'b1;                        // see (R11)
      end
    end
  end

  // --------------------------------------------------------------------
  // Command pulses
  // --------------------------------------------------------------------
  // Power-on may go any time; the rest wait for the settled robot, except start, stop and shutdown given with power-on
  assign any_req = req_start | req_stop | req_pause | req_shutdown |
                   req_warn_clear | req_teach;
  assign cmd_ready = press_cnt == '0 && (alive_settled || !any_req);

  // Momentary lines are held for one press time, then released
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      press_cnt  <= '0;
      press_bits <= '0;
    end else if (press_cnt != '0) begin
      press_cnt <= press_cnt - 32'h1;
      if (press_cnt == 32'h1) begin
        press_bits <= '0;
      end
    end else if (req_power_on || (alive_settled && any_req)) begin
      press_cnt  <= PRESS_CYC;                        // see (R15)
      press_bits <= {req_warn_clear && alive_settled, req_shutdown,
                     req_power_on, req_stop, req_start, 1'b0};
    end
  end

  // Latching lines flip once per accepted press
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link.prog_pause_in  <= 1'b0;
      link.force_teach_in <= 1'b0;
    end else if (press_cnt == '0 && alive_settled) begin
      link.prog_pause_in  <= link.prog_pause_in ^ req_pause;   // see (R15)
      link.force_teach_in <= link.force_teach_in ^ req_teach;  // see (R15)
    end
  end

  assign link.prog_start_in      = press_bits[1];
  assign link.prog_stop_in       = press_bits[2];
  assign link.remote_power_on_in = press_bits[3];
  assign link.remote_shutdown_in = press_bits[4];
  assign link.warning_clear_in   = press_bits[5];
  assign link.return_home_in     = hold_home && alive_settled;  // see (R6)

  // --------------------------------------------------------------------
  // Status capture
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
      stopped <= 1'b0;
      paused  <= 1'b0;
      at_home <= 1'b0;
    end else begin
      running <= link.running_out;
      stopped <= link.stopped_out;
      paused  <= link.paused_out;
      at_home <= link.at_home_out;
    end
  end

endmodule : lios_host

`default_nettype wire

// *** bench/lios_chk.sv ***
// Checker on the linkage I/O lines between the two ends.
`timescale 1ns/100ps
`default_nettype none
`include "lios_map.svh"

module lios_chk #(
  parameter int unsigned ALIVE_WAIT_CYC = `LIOS_ALIVE_WAIT_CYC,
  parameter int unsigned PRESS_CYC      = `LIOS_PRESS_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic prog_start_in,
  input wire logic prog_stop_in,
  input wire logic prog_pause_in,
  input wire logic return_home_in,
  input wire logic remote_power_on_in,
  input wire logic remote_shutdown_in,
  input wire logic warning_clear_in,
  input wire logic force_teach_in,
  input wire logic running_out,
  input wire logic stopped_out,
  input wire logic paused_out,
  input wire logic at_home_out,
  input wire logic software_alive_out
);
  // --------
  // Helper counters
  // --------
  logic [31:0] press_len;
  logic [31:0] alive_cnt;
  logic [3:0]  since_evt;
  logic        mom;

  // Any momentary pin; presses given together share one length
  assign mom = prog_start_in | prog_stop_in | remote_power_on_in
             | remote_shutdown_in | warning_clear_in;

  // Press length, alive age and age of the last program or shutdown command
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      press_len <= 32'h0;
      alive_cnt <= 32'h0;
      since_evt <= 4'hF;
    end else begin
      press_len <= mom ? press_len + 32'h1 : 32'h0;
      // Saturate so a long run never wraps back under the wait
      if (!software_alive_out) begin
        alive_cnt <= 32'h0;
      end else if (alive_cnt != 32'hFFFFFFFF) begin
        alive_cnt <= alive_cnt + 32'h1;
      end
      if ($rose(prog_start_in) || $rose(prog_stop_in)
          || $rose(remote_shutdown_in) || $changed(prog_pause_in)) begin
        since_evt <= 4'h0;
      end else if (since_evt != 4'hF) begin
        since_evt <= since_evt + 4'h1;
      end
    end
  end

  // --------
  // Assertions
  // --------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  run_stop_excl_a :
    assert property (!(running_out && stopped_out))
    else $error("running and stopped both high");
  run_pause_excl_a :
    assert property (!(running_out && paused_out))
    else $error("running and paused both high");
  run_home_excl_a :
    assert property (running_out |-> !at_home_out)
    else $error("at home while running");
  idle_stopped_a :
    assert property (!running_out && !paused_out |-> stopped_out)
    else $error("idle without stopped");
  pause_entry_a :
    assert property ($rose(paused_out) |-> $fell(running_out))
    else $error("paused entered not from running");
  pause_exit_a :
    assert property ($fell(paused_out) |->
                     $rose(running_out) || $rose(stopped_out))
    else $error("paused left to no state");
  status_cause_a :
    assert property ($rose(running_out) || $rose(stopped_out) |->
                     since_evt <= 4'h8)
    else $error("status change without a command");
  home_held_a :
    assert property ($rose(at_home_out) |-> $past(return_home_in))
    else $error("at home without home request held");
  press_len_a :
    assert property ($fell(mom) |-> press_len == PRESS_CYC)
    else $error("momentary press of wrong length");
  alive_wait_a :
    assert property ($rose(prog_start_in) || $rose(prog_stop_in)
                     || $changed(prog_pause_in) |->
                     alive_cnt >= ALIVE_WAIT_CYC)
    else $error("command too soon after software alive");
endmodule : lios_chk

`default_nettype wire

// *** bench/test_linkage_io_sequencer.sv ***
// Self-checking bench joining both ends of the linkage I/O sequencer.
`timescale 1ns/100ps
`default_nettype none

module test_linkage_io_sequencer;
  // --------
  // Signals
  // --------
  localparam int RUN = 0, STP = 1, PSD = 2, HOM = 3, ALV = 4, PWR = 5;
  localparam int MHM = 6, TCH = 7, WRN = 8, SET = 9, MRN = 10;
  localparam int HRN = 11, HST = 12, HPS = 13, HHM = 14, WCP = 15;
  localparam int Q_STA = 0, Q_STP = 1, Q_PAU = 2, Q_PWR = 3;
  localparam int Q_SHT = 4, Q_WCL = 5, Q_TCH = 6;
  logic        ref_clk;
  logic        resetn;
  logic        linkage_mode;
  logic        collision;
  logic        home_reached;
  logic        boot_done;
  logic [6:0]  rq;
  logic        hold_home;
  logic        cmd_ready;
  logic        system_power, motion_run, motion_home, teach_enable;
  logic        warning_pending, alive_settled;
  logic        h_run, h_stp, h_psd, h_hom, wclr_pulse;
  logic [15:0] obs;
  int          miscompares;
  int          checks;

  lios_if link ();

  // Status gathered into one vector for the check tasks
  assign obs = {wclr_pulse, h_hom, h_psd, h_stp, h_run,
                motion_run, alive_settled, warning_pending, teach_enable,
                motion_home, system_power, link.software_alive_out,
                link.at_home_out, link.paused_out, link.stopped_out,
                link.running_out};

  lios_device lios_device_i (
    .ref_clk(ref_clk), .resetn(resetn), .link(link.dev),
    .linkage_mode(linkage_mode), .collision(collision),
    .home_reached(home_reached), .boot_done(boot_done),
    .system_power(system_power), .motion_run(motion_run),
    .motion_home(motion_home), .teach_enable(teach_enable),
    .warning_pending(warning_pending), .warning_clear_pulse(wclr_pulse)
  );

  // Short counts keep the run brief
  lios_host #(.ALIVE_WAIT_CYC(20), .PRESS_CYC(4)) lios_host_i (
    .ref_clk(ref_clk), .resetn(resetn), .link(link.host),
    .req_start(rq[0]), .req_stop(rq[1]), .req_pause(rq[2]),
    .req_power_on(rq[3]), .req_shutdown(rq[4]), .req_warn_clear(rq[5]),
    .req_teach(rq[6]), .hold_home(hold_home), .cmd_ready(cmd_ready),
    .running(h_run), .stopped(h_stp), .paused(h_psd), .at_home(h_hom),
    .alive_settled(alive_settled)
  );

  lios_chk #(.ALIVE_WAIT_CYC(20), .PRESS_CYC(4)) lios_chk_i (
    .ref_clk(ref_clk), .resetn(resetn),
    .prog_start_in(link.prog_start_in), .prog_stop_in(link.prog_stop_in),
    .prog_pause_in(link.prog_pause_in),
    .return_home_in(link.return_home_in),
    .remote_power_on_in(link.remote_power_on_in),
    .remote_shutdown_in(link.remote_shutdown_in),
    .warning_clear_in(link.warning_clear_in),
    .force_teach_in(link.force_teach_in),
    .running_out(link.running_out), .stopped_out(link.stopped_out),
    .paused_out(link.paused_out), .at_home_out(link.at_home_out),
    .software_alive_out(link.software_alive_out)
  );

  // --------
  // Tasks
  // --------
  task automatic chk(input int b, input logic v);
    checks++;
    if (obs[b] !== v) begin
      miscompares++;
      $display("mismatch at %0t: status bit %0d is %b", $time, b, obs[b]);
    end
  endtask : chk

  // Bounded wait, then compare; all waits sit on falling edges
  task automatic await(input int b, input logic v);
    int n;
    n = 0;
    while (obs[b] !== v && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    chk(b, v);
  endtask : await

  // Request held one cycle; the host takes it while ready
  task automatic req(input int k);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    if (cmd_ready !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: host never ready", $time);
    end
    rq[k] = 1'b1;
    @(negedge ref_clk);
    rq[k] = 1'b0;
  endtask : req

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // --------
  // Clock, watchdog and sequence
  // --------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    resetn = 1'b0;
    rq = 7'h00;
    hold_home = 1'b0;
    linkage_mode = 1'b1;
    collision = 1'b0;
    home_reached = 1'b0;
    boot_done = 1'b0;
    miscompares = 0;
    checks = 0;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    chk(STP, 1'b1);
    chk(RUN, 1'b0);
    chk(HST, 1'b0);
    await(HST, 1'b1);
    req(Q_PWR);
    await(PWR, 1'b1);
    chk(ALV, 1'b0);
    boot_done = 1'b1;
    await(ALV, 1'b1);
    await(SET, 1'b1);
    // Homing moves only while held
    hold_home = 1'b1;
    await(MHM, 1'b1);
    repeat (5) @(negedge ref_clk);
    chk(HOM, 1'b0);
    chk(STP, 1'b1);
    home_reached = 1'b1;
    await(HOM, 1'b1);
    await(HHM, 1'b1);
    hold_home = 1'b0;
    await(MHM, 1'b0);
    home_reached = 1'b0;
    req(Q_STA);
    await(RUN, 1'b1);
    chk(STP, 1'b0);
    chk(HOM, 1'b0);
    chk(MRN, 1'b1);
    await(HRN, 1'b1);
    chk(HST, 1'b0);
    chk(HHM, 1'b0);
    req(Q_PAU);
    await(PSD, 1'b1);
    chk(RUN, 1'b0);
    await(HPS, 1'b1);
    req(Q_PAU);
    await(RUN, 1'b1);
    chk(PSD, 1'b0);
    // Collision: resume refused until the warning is cleared
    collision = 1'b1;
    @(negedge ref_clk);
    collision = 1'b0;
    await(PSD, 1'b1);
    chk(WRN, 1'b1);
    req(Q_PAU);
    repeat (10) @(negedge ref_clk);
    chk(RUN, 1'b0);
    req(Q_WCL);
    await(WRN, 1'b0);
    chk(WCP, 1'b1);
    @(negedge ref_clk);
    chk(WCP, 1'b0);
    req(Q_PAU);
    await(RUN, 1'b1);
    chk(PSD, 1'b0);
    req(Q_TCH);
    await(TCH, 1'b1);
    req(Q_TCH);
    await(TCH, 1'b0);
    req(Q_STP);
    await(STP, 1'b1);
    chk(RUN, 1'b0);
    await(HST, 1'b1);
    // Manual mode: program lines ignored, power lines still obeyed
    linkage_mode = 1'b0;
    hold_home = 1'b1;
    req(Q_STA);
    req(Q_TCH);
    repeat (12) @(negedge ref_clk);
    chk(RUN, 1'b0);
    chk(MHM, 1'b0);
    chk(TCH, 1'b0);
    hold_home = 1'b0;
    req(Q_SHT);
    await(PWR, 1'b0);
    req(Q_PWR);
    await(PWR, 1'b1);
    conclude();
  end
endmodule : test_linkage_io_sequencer

`default_nettype wire
